// *** ffb_pkg.sv ***
/*
  package for the fault status flag bank: register offsets, field
  positions, reset values and reserved-bit masks.
  assumes: an 8-bit register port from the serial control slave.
*/
package ffb_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ffb_rail_fault_two_offset = 8'hB3;
  localparam logic [7:0] ffb_critical_temp_offset = 8'hB4;
  localparam logic [7:0] ffb_hot_temp_offset = 8'hB5;
  localparam logic [7:0] ffb_overcurrent_offset = 8'hB6;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] ffb_rail_fault_two_reset = 8'h00;
  localparam logic [7:0] ffb_critical_temp_reset = 8'h00;
  localparam logic [7:0] ffb_hot_temp_reset = 8'h00;
  localparam logic [7:0] ffb_overcurrent_reset = 8'h00;

  // ------------------------------------------------------------
  // implemented-bit masks (reserved bits are zero here)
  // ------------------------------------------------------------
  localparam logic [7:0] ffb_rail_fault_two_mask = 8'h1F;
  localparam logic [7:0] ffb_temperature_mask = 8'h1F;
  localparam logic [7:0] ffb_overcurrent_mask = 8'h07;

  // ------------------------------------------------------------
  // rail fault field positions
  // ------------------------------------------------------------
  localparam int ffb_gp_regulator_one_fault_bit = 4;
  localparam int ffb_termination_regulator_fault_bit = 3;
  localparam int ffb_load_switch_b_two_fault_bit = 2;
  localparam int ffb_load_switch_b_one_fault_bit = 1;
  localparam int ffb_regulator_three_fault_bit = 0;

  // ------------------------------------------------------------
  // temperature sensor positions (shared by critical and hot)
  // ------------------------------------------------------------
  localparam int ffb_remaining_die_bit = 4;
  localparam int ffb_termination_regulator_bit = 3;
  localparam int ffb_upper_right_bit = 2;
  localparam int ffb_upper_left_bit = 1;
  localparam int ffb_lower_right_bit = 0;

  // ------------------------------------------------------------
  // overcurrent field positions
  // ------------------------------------------------------------
  localparam int ffb_step_down_six_overcurrent_bit = 2;
  localparam int ffb_step_down_two_overcurrent_bit = 1;
  localparam int ffb_step_down_one_overcurrent_bit = 0;

endpackage

// *** ffb_fault_status_flag_bank.sv ***
/*
  fault status flag bank: four sticky write-1-to-clear registers
  collecting rail regulation loss, critical and hot temperature and
  low-side switch overcurrent events.
  assumes: detector inputs are synchronised twice here since they come
  from analog comparators; the register port comes from the serial
  control slave on the same clock, one-cycle write and read strobes.
*/
`timescale 1ns/1ps

// Overview of operation
// [RULE1] gp regulator one loss sets bit 4
// [RULE2] termination regulator loss sets bit 3
// [RULE3] load switch b two loss sets bit 2
// [RULE4] load switch b one loss sets bit 1
// [RULE5] regulator three loss sets bit 0
// [RULE6] rail flag reads 1, write 1 clears
// [RULE7] rail fault register at B3h, resets zero
// [RULE8] critical sensor crossing sets its flag
// [RULE9] critical bits: die, termination, corners
// [RULE10] critical register at B4h, resets zero
// [RULE11] hot sensor crossing sets its flag
// [RULE12] hot bits mapped like critical bits
// [RULE13] hot register at B5h, resets zero
// [RULE14] temperature flag reads 1, write 1 clears
// [RULE15] overcurrent at B6h, bits six, two, one
// [RULE16] overcurrent resets zero, bits 7-3 reserved
// [RULE17] overcurrent flag reads 1, write 1 clears
// [RULE18] flags sticky; writing 0 leaves unchanged
// [RULE19] reserved bits read zero, ignore writes
// [RULE20] set wins over simultaneous clear
module ffb_fault_status_flag_bank
  import ffb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_address,
  input wire logic reg_write,
  input wire logic [7:0] reg_write_data,
  input wire logic reg_read,
  output logic [7:0] reg_read_data,
  output logic reg_read_valid,
  // rail regulation loss detectors, bit per rail
  input wire logic gp_regulator_one_fault,
  input wire logic termination_regulator_fault,
  input wire logic load_switch_b_two_fault,
  input wire logic load_switch_b_one_fault,
  input wire logic regulator_three_fault,
  // temperature sensors above critical threshold, bit 4 down to 0
  input wire logic [4:0] sensor_above_critical_threshold,
  // temperature sensors above hot threshold, same ordering
  input wire logic [4:0] sensor_above_hot_threshold,
  // low-side switch overcurrent detectors
  input wire logic step_down_six_overcurrent,
  input wire logic step_down_two_overcurrent,
  input wire logic step_down_one_overcurrent
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // next value of a sticky w1c flag byte; set beats clear
  function automatic logic [7:0] sticky_next(input logic [7:0] current,
                                             input logic [7:0] events,
                                             input logic [7:0] clear,
                                             input logic [7:0] mask);
    logic [7:0] result;
    result = ((current & ~clear) | events) & mask;
    return result;
  endfunction

  // ------------------------------------------------------------
  // detector synchronisers
  // ------------------------------------------------------------
  // detectors are asynchronous to the register clock; two flops each.
  // the first stage is read by the second stage only.
  logic [17:0] detect_meta; // first stage
  logic [17:0] detect_sync; // second stage, safe to use
  logic [17:0] detect_raw; // gathered detector pins

  assign detect_raw = {step_down_six_overcurrent, step_down_two_overcurrent,
                       step_down_one_overcurrent, sensor_above_hot_threshold,
                       sensor_above_critical_threshold, gp_regulator_one_fault,
                       termination_regulator_fault, load_switch_b_two_fault,
                       load_switch_b_one_fault, regulator_three_fault};

  // two-flop capture of all detectors
  always_ff @(posedge clock) begin
    if (reset) begin
      detect_meta <= '0;
      detect_sync <= '0;
    end else begin
      detect_meta <= detect_raw;
      detect_sync <= detect_meta;
    end
  end

  // ------------------------------------------------------------
  // event vectors per register
  // ------------------------------------------------------------
  logic [7:0] rail_events; // regulation loss events
  logic [7:0] critical_events; // critical temperature events
  logic [7:0] hot_events; // hot temperature events
  logic [7:0] overcurrent_events; // low-side overcurrent events

  // [RULE1] gp regulator one placement
  // [RULE2] termination regulator placement
  // [RULE3] load switch b two placement
  // [RULE4] load switch b one placement
  // [RULE5] regulator three placement
  always_comb begin
    rail_events = 8'h00;
    rail_events[ffb_gp_regulator_one_fault_bit] = detect_sync[4];
    rail_events[ffb_termination_regulator_fault_bit] = detect_sync[3];
    rail_events[ffb_load_switch_b_two_fault_bit] = detect_sync[2];
    rail_events[ffb_load_switch_b_one_fault_bit] = detect_sync[1];
    rail_events[ffb_regulator_three_fault_bit] = detect_sync[0];
  end

  // [RULE8] critical sensor events
  // [RULE9] critical bit mapping
  always_comb begin
    critical_events = 8'h00;
    critical_events[ffb_remaining_die_bit] = detect_sync[9];
    critical_events[ffb_termination_regulator_bit] = detect_sync[8];
    critical_events[ffb_upper_right_bit] = detect_sync[7];
    critical_events[ffb_upper_left_bit] = detect_sync[6];
    critical_events[ffb_lower_right_bit] = detect_sync[5];
  end

  // [RULE11] hot sensor events
  // [RULE12] hot shares critical mapping
  always_comb begin
    hot_events = 8'h00;
    hot_events[ffb_remaining_die_bit] = detect_sync[14];
    hot_events[ffb_termination_regulator_bit] = detect_sync[13];
    hot_events[ffb_upper_right_bit] = detect_sync[12];
    hot_events[ffb_upper_left_bit] = detect_sync[11];
    hot_events[ffb_lower_right_bit] = detect_sync[10];
  end

  // [RULE15] overcurrent bit placement
  always_comb begin
    overcurrent_events = 8'h00;
    overcurrent_events[ffb_step_down_six_overcurrent_bit] = detect_sync[17];
    overcurrent_events[ffb_step_down_two_overcurrent_bit] = detect_sync[16];
    overcurrent_events[ffb_step_down_one_overcurrent_bit] = detect_sync[15];
  end

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic [7:0] rail_clear; // clear strobes per register
  logic [7:0] critical_clear;
  logic [7:0] hot_clear;
  logic [7:0] overcurrent_clear;

  // write data acts only as clear strobes; zeros are harmless
  always_comb begin
    rail_clear = 8'h00;
    critical_clear = 8'h00;
    hot_clear = 8'h00;
    overcurrent_clear = 8'h00;
    if (reg_write) begin
      case (reg_address)
        ffb_rail_fault_two_offset: rail_clear = reg_write_data;
        ffb_critical_temp_offset: critical_clear = reg_write_data;
        ffb_hot_temp_offset: hot_clear = reg_write_data;
        ffb_overcurrent_offset: overcurrent_clear = reg_write_data;
        default: rail_clear = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // flag registers
  // ------------------------------------------------------------
  logic [7:0] rail_fault_status_two; // rail regulation loss flags
  logic [7:0] critical_temperature_status; // critical temperature flags
  logic [7:0] hot_temperature_status; // hot temperature flags
  logic [7:0] overcurrent_status; // overcurrent flags

  // [RULE7] rail register resets zero
  // [RULE6] rail write one clears
  always_ff @(posedge clock) begin
    if (reset) begin
      rail_fault_status_two <= ffb_rail_fault_two_reset;
    end else begin
      rail_fault_status_two <= sticky_next(rail_fault_status_two, rail_events,
                                           rail_clear, ffb_rail_fault_two_mask);
    end
  end

  // [RULE10] critical register resets zero
  // [RULE14] temperature write one clears
  always_ff @(posedge clock) begin
    if (reset) begin
      critical_temperature_status <= ffb_critical_temp_reset;
    end else begin
      critical_temperature_status <= sticky_next(critical_temperature_status,
                                                 critical_events, critical_clear,
                                                 ffb_temperature_mask);
    end
  end

  // [RULE13] hot register resets zero
  // [RULE18] sticky until cleared
  always_ff @(posedge clock) begin
    if (reset) begin
      hot_temperature_status <= ffb_hot_temp_reset;
    end else begin
      hot_temperature_status <= sticky_next(hot_temperature_status, hot_events,
                                            hot_clear, ffb_temperature_mask);
    end
  end

  // [RULE16] overcurrent resets zero, reserved masked
  // [RULE17] overcurrent write one clears
  // [RULE20] set beats clear
  always_ff @(posedge clock) begin
    if (reset) begin
      overcurrent_status <= ffb_overcurrent_reset;
    end else begin
      overcurrent_status <= sticky_next(overcurrent_status, overcurrent_events,
                                        overcurrent_clear, ffb_overcurrent_mask);
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [7:0] next_read_data; // selected register

  // [RULE19] reserved bits read zero
  always_comb begin
    case (reg_address)
      ffb_rail_fault_two_offset: next_read_data = rail_fault_status_two;
      ffb_critical_temp_offset: next_read_data = critical_temperature_status;
      ffb_hot_temp_offset: next_read_data = hot_temperature_status;
      ffb_overcurrent_offset: next_read_data = overcurrent_status;
      // other offsets belong to other banks; answer zero
      default: next_read_data = 8'h00;
    endcase
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_read_data <= 8'h00;
      reg_read_valid <= 1'b0;
    end else begin
      reg_read_valid <= reg_read;
      if (reg_read) begin
        reg_read_data <= next_read_data;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_rail_event_sets: assert property ( // [RULE1]
    @(posedge clock) disable iff (reset)
    detect_sync[4] |=> rail_fault_status_two[4])
    else $error("rail bit 4 not set after event");

  a_termination_sets: assert property ( // [RULE2]
    @(posedge clock) disable iff (reset)
    $rose(termination_regulator_fault) |-> ##3 rail_fault_status_two[3])
    else $error("rail bit 3 not set three cycles after detector");

  a_rail_sticky_hold: assert property ( // [RULE18]
    @(posedge clock) disable iff (reset)
    (rail_fault_status_two[2] && !(reg_write && reg_address == ffb_rail_fault_two_offset
      && reg_write_data[2])) |=> rail_fault_status_two[2])
    else $error("rail flag dropped without clear");

  a_rail_clear_works: assert property ( // [RULE6]
    @(posedge clock) disable iff (reset)
    (reg_write && reg_address == ffb_rail_fault_two_offset
      && reg_write_data[1] && !detect_sync[1])
    |=> !rail_fault_status_two[1])
    else $error("rail flag not cleared by write one");

  a_set_beats_clear: assert property ( // [RULE20]
    @(posedge clock) disable iff (reset)
    (reg_write && reg_address == ffb_overcurrent_offset
      && reg_write_data[0] && detect_sync[15])
    |=> overcurrent_status[0])
    else $error("clear beat a simultaneous set");

  a_critical_sets: assert property ( // [RULE9]
    @(posedge clock) disable iff (reset)
    detect_sync[9] |=> critical_temperature_status[4])
    else $error("critical die flag not set");

  a_hot_clear_works: assert property ( // [RULE14]
    @(posedge clock) disable iff (reset)
    (reg_write && reg_address == ffb_hot_temp_offset
      && reg_write_data[3] && !detect_sync[13])
    |=> !hot_temperature_status[3])
    else $error("hot flag not cleared");

  a_reserved_zero: assert property ( // [RULE19]
    @(posedge clock) disable iff (reset)
    reg_read_valid |-> (reg_read_data[7:5] == 3'b000))
    else $error("reserved bits read nonzero");

  a_overcurrent_read: assert property ( // [RULE15]
    @(posedge clock) disable iff (reset)
    (reg_read && reg_address == ffb_overcurrent_offset)
      |=> reg_read_data == $past(overcurrent_status))
    else $error("overcurrent read mismatch");

endmodule

// *** ffb_host_model.sv ***
/*
  host processor model for the fault status flag bank: issues one-cycle
  write and read strobes on the register port and hands back read data.
  assumes: same clock as the flag bank, requests launched 1 ns after edge.
*/
`timescale 1ns/1ps

module ffb_host_model (
  // clock
  input wire logic clock,
  // register port toward the device
  output logic [7:0] reg_address,
  output logic reg_write,
  output logic [7:0] reg_write_data,
  output logic reg_read,
  input wire logic [7:0] reg_read_data,
  input wire logic reg_read_valid
);

  // ------------------------------------------------------------
  // idle bus values at time zero
  // ------------------------------------------------------------
  initial begin
    reg_address = 8'h00;
    reg_write = 1'b0;
    reg_write_data = 8'h00;
    reg_read = 1'b0;
  end

  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // clear by one
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    #1;
    reg_write = 1'b1;
    reg_address = addr;
    reg_write_data = data;
    @(posedge clock);
    #1;
    reg_write = 1'b0;
    // released lines show the inverse so a stale value never looks valid
    reg_address = ~addr;
    reg_write_data = ~data;
  endtask

  // answer is registered: taken one edge after the strobe edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic valid);
    @(posedge clock);
    #1;
    reg_read = 1'b1;
    reg_address = addr;
    @(posedge clock);
    #1;
    data = reg_read_data;
    valid = reg_read_valid;
    reg_read = 1'b0;
    reg_address = ~addr;
  endtask

endmodule

// *** tb.sv ***
/*
  self-checking bench for the fault status flag bank: random detector
  bursts, random write-one clears, unmapped accesses, set-over-clear and
  a reset in mid-run.
  assumes: the host model drives the register port; bench drives detectors.
*/
`timescale 1ns/1ps

module tb;
  import ffb_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clock; // 25 MHz
  logic reset; // synchronous, active high
  logic [7:0] reg_address;
  logic reg_write;
  logic [7:0] reg_write_data;
  logic reg_read;
  logic [7:0] reg_read_data;
  logic reg_read_valid;
  logic [17:0] events; // rail [4:0], critical [9:5], hot [14:10], oc [17:15]
  logic [7:0] exp_flag [4]; // expected register contents
  int miscompares;
  int n_compared;
  integer seed;
  localparam logic [7:0] offs [4] = '{ffb_rail_fault_two_offset,
    ffb_critical_temp_offset, ffb_hot_temp_offset, ffb_overcurrent_offset};
  localparam logic [7:0] masks [4] = '{ffb_rail_fault_two_mask,
    ffb_temperature_mask, ffb_temperature_mask, ffb_overcurrent_mask};

  // ------------------------------------------------------------
  // clock
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  ffb_fault_status_flag_bank i_ffb_fault_status_flag_bank (
    .clock(clock), .reset(reset), .reg_address(reg_address),
    .reg_write(reg_write), .reg_write_data(reg_write_data),
    .reg_read(reg_read), .reg_read_data(reg_read_data),
    .reg_read_valid(reg_read_valid),
    .gp_regulator_one_fault(events[4]), .termination_regulator_fault(events[3]),
    .load_switch_b_two_fault(events[2]), .load_switch_b_one_fault(events[1]),
    .regulator_three_fault(events[0]),
    .sensor_above_critical_threshold(events[9:5]),
    .sensor_above_hot_threshold(events[14:10]),
    .step_down_six_overcurrent(events[17]), .step_down_two_overcurrent(events[16]),
    .step_down_one_overcurrent(events[15]));

  ffb_host_model i_ffb_host_model (
    .clock(clock), .reg_address(reg_address), .reg_write(reg_write),
    .reg_write_data(reg_write_data), .reg_read(reg_read),
    .reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid));

  // ------------------------------------------------------------
  // expectation functions and checking tasks
  // ------------------------------------------------------------
  // detector vector slice that lands in register i
  function automatic logic [7:0] ev_byte(input int i, input logic [17:0] e);
    case (i)
      0: return {3'h0, e[4:0]};
      1: return {3'h0, e[9:5]};
      2: return {3'h0, e[14:10]};
      default: return {5'h00, e[17:15]};
    endcase
  endfunction

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] expected);
    n_compared++;
    if (seen !== expected) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, expected, seen);
    end
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [7:0] expected);
    logic [7:0] d;
    logic v;
    i_ffb_host_model.read_reg(addr, d, v);
    check("read_valid", {7'h00, v}, 8'h01);
    check($sformatf("reg_%h", addr), d, expected);
  endtask

  task automatic read_all();
    for (int i = 0; i < 4; i++) begin
      read_check(offs[i], exp_flag[i]);
    end
  endtask

  // detectors held two cycles, then three more for the synchroniser
  task automatic pulse(input logic [17:0] e);
    @(posedge clock);
    #1 events = e;
    repeat (2) @(posedge clock);
    #1 events = 18'h00000;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      exp_flag[i] = (exp_flag[i] | ev_byte(i, e)) & masks[i];
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // watchdog: well beyond the roughly 1200 cycles the run needs
  // ------------------------------------------------------------
  initial begin
    #(20000 * 40);
    miscompares++;
    stop_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0] addr;
    logic [7:0] clr;
    seed = 32'h69DA;
    reset = 1'b1;
    events = 18'h00000;
    miscompares = 0;
    n_compared = 0;
    exp_flag = '{ffb_rail_fault_two_reset, ffb_critical_temp_reset,
      ffb_hot_temp_reset, ffb_overcurrent_reset};
    repeat (5) @(posedge clock);
    #1 reset = 1'b0;
    read_all(); // reset values
    // first pass sets every detector, second writes zeros
    for (int it = 0; it < 40; it++) begin
      r = $random(seed);
      pulse(it == 0 ? 18'h3FFFF : r[17:0]);
      read_all(); // bit mapping, sticky flags
      addr = 8'($random(seed));
      if (addr >= ffb_rail_fault_two_offset && addr <= ffb_overcurrent_offset) begin
        addr = 8'hB7;
      end
      i_ffb_host_model.write_reg(addr, 8'hFF);
      read_check(addr, 8'h00); // unmapped reads zero
      clr = (it == 1) ? 8'h00 : 8'($random(seed));
      i_ffb_host_model.write_reg(offs[it % 4], clr);
      exp_flag[it % 4] = exp_flag[it % 4] & ~clr;
      read_all(); // write one clears
    end
    pulse(18'h3FFFF);
    @(posedge clock);
    // hold remaining die critical and step-down one overcurrent during clears
    #1 events = 18'h08200;
    repeat (4) @(posedge clock);
    i_ffb_host_model.write_reg(ffb_critical_temp_offset, 8'hFF);
    i_ffb_host_model.write_reg(ffb_overcurrent_offset, 8'hFF);
    exp_flag[1] = ev_byte(1, 18'h08200);
    exp_flag[3] = ev_byte(3, 18'h08200);
    read_all(); // held detector survives clear
    // a reset in mid-run empties every register
    pulse(18'h3FFFF);
    #1 reset = 1'b1;
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    exp_flag = '{8'h00, 8'h00, 8'h00, 8'h00};
    read_all(); // reset clears all
    stop_test();
  end

endmodule
